// ### dil_defs.svh
// Constants of the DAC input loading controller
`ifndef DIL_DEFS_SVH
`define DIL_DEFS_SVH
// Register offsets of the controller's own register file
`define DIL_ADDR_DATA    4'h0
`define DIL_ADDR_CTRL    4'h1
`define DIL_ADDR_STATUS  4'h2
`define DIL_ADDR_READBK  4'h3
// Control register fields
`define DIL_CTRL_MODE_LO 0
`define DIL_CTRL_MODE_HI 1
`define DIL_CTRL_GO      2
`define DIL_CTRL_SHORT   3
// Status register fields
`define DIL_STAT_BUSY    0
`define DIL_STAT_DONE    1
// Reset values
`define DIL_DATA_RST     10'h000
// Timing: minimum load level time in ns, and clock period in ns
`define DIL_LOAD_MIN_NS  500
`define DIL_CLK_NS       5
`define DIL_LOAD_CYC     ((`DIL_LOAD_MIN_NS + `DIL_CLK_NS - 1) / `DIL_CLK_NS)
// Strobe half period in link clock cycles
`define DIL_STB_HALF     2
`endif

// ### dil_pkg.sv
// Types of the DAC input loading controller
package dil_pkg;
  typedef enum logic [1:0]
  {
    DIL_MODE_SINGLE = 2'b00,
    DIL_MODE_TWO    = 2'b01,
    DIL_MODE_SER10  = 2'b10,
    DIL_MODE_SER8   = 2'b11
  } dil_mode_e;
  typedef enum logic [2:0]
  {
    DIL_ST_IDLE  = 3'b000,
    DIL_ST_SETUP = 3'b001,
    DIL_ST_HIGH  = 3'b010,
    DIL_ST_LOW   = 3'b011,
    DIL_ST_NEXT  = 3'b100,
    DIL_ST_DONE  = 3'b101
  } dil_state_e;
endpackage

// ### dil_ctrl.sv
// Host side controller that loads a 10-bit buffered DAC through its pins
// Function
// - The load level is held high for at least 0.5 us.
// - Two-byte loading sends the low eight bits first with a low byte strobe edge.
// - The high two bits follow later with a high byte strobe edge, the bus free in between.
// - The load level is raised only at or after the high byte strobe edge.
// - Serial 10-bit loading gives exactly 10 joint rising edges with the short cycle control high.
// - Serial 8-bit loading gives exactly 8 joint rising edges with the short cycle control low.
// - All ten parallel data pins are held low while loading serially.
// - Single byte use of low-linearity grades ties the lowest one or two data pins low.
`timescale 1ns/100ps
`include "dil_defs.svh"
module dil_ctrl
  import dil_pkg::*;
#(
  parameter int LOAD_CYC  = `DIL_LOAD_CYC,
  parameter int GAP_CYC   = 4,
  parameter int GRADE_TIE = 0
)
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_link_clk,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic      [9:0]  o_parallel_data_bits,
  output logic             o_low_byte_strobe,
  output logic             o_high_byte_strobe,
  output logic             o_register_load_level,
  output logic             o_serial_parallel_select,
  output logic             o_short_cycle_n,
  output logic             o_serial_data_in,
  input  wire logic        i_serial_data_out
);

  // Refuse values the 16-bit counter or the pin mask cannot serve, at elaboration
  if (LOAD_CYC < 1 || GAP_CYC < 1 || GAP_CYC > 65536 || LOAD_CYC > 65536 || GRADE_TIE < 0 || GRADE_TIE > 2)
  begin : g_param_check
    $error("dil_ctrl: unsupported parameter value");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file on the system clock

  logic [9:0]  data_r;
  logic [1:0]  mode_r;
  logic        go_tgl_r;
  logic        done_r;
  logic [9:0]  readbk_r;
  logic [2:0]  done_sync_r;
  logic [1:0]  sro_sync_r;
  logic        busy_r;
  logic        link_done_tgl_r;

  // Word and mode; a write with the go bit starts a transfer unless busy
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      data_r   <= `DIL_DATA_RST;
      mode_r   <= 2'h0;
      go_tgl_r <= 1'b0;
    end
    else if (i_wr && !busy_r)
    begin
      if (i_addr == `DIL_ADDR_DATA)
        data_r <= i_wdata[9:0];
      if (i_addr == `DIL_ADDR_CTRL)
      begin
        mode_r <= i_wdata[`DIL_CTRL_MODE_HI:`DIL_CTRL_MODE_LO];
        if (i_wdata[`DIL_CTRL_GO])
          go_tgl_r <= ~go_tgl_r;
      end
    end
  end

  // Done toggle crosses back through two flops; third stage only detects the edge
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      done_sync_r <= 3'h0;
    else
      done_sync_r <= {done_sync_r[1:0], link_done_tgl_r};
  end

  // Busy from go until done returns; done is sticky, set wins over read clear
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      if (i_wr && !busy_r && i_addr == `DIL_ADDR_CTRL && i_wdata[`DIL_CTRL_GO])
        busy_r <= 1'b1;
      else if (done_sync_r[2] != done_sync_r[1])
        busy_r <= 1'b0;
      if (done_sync_r[2] != done_sync_r[1])
        done_r <= 1'b1;
      else if (i_rd && i_addr == `DIL_ADDR_STATUS)
        done_r <= 1'b0;
    end
  end

  // Serial readback from the DAC's auxiliary output, two-flop synchronised
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      sro_sync_r <= 2'h0;
    else
      sro_sync_r <= {sro_sync_r[0], i_serial_data_out};
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      case (i_addr)
        `DIL_ADDR_DATA:   o_rdata <= {6'h00, data_r};
        `DIL_ADDR_CTRL:   o_rdata <= {14'h0000, mode_r};
        `DIL_ADDR_STATUS: o_rdata <= {13'h0000, sro_sync_r[1], done_r, busy_r};
        `DIL_ADDR_READBK: o_rdata <= {6'h00, readbk_r};
        default:          o_rdata <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: pin sequencer on the link clock

  logic [2:0]  go_sync_r;
  logic [9:0]  word_r;
  dil_mode_e   lmode_r;
  dil_state_e  state_r;
  logic [3:0]  bit_r;
  logic [15:0] cnt_r;
  logic        phase_r;
  logic [9:0]  shadow_r;

  // Load time counted on the system clock, rescaled to link cycles (16x slower)
  localparam int LINK_LOAD = (LOAD_CYC + 15) / 16 + 1;

  // Mask off the lowest pins a lower linearity grade must tie low
  function automatic logic [9:0] grade_mask(input logic [9:0] w);
    logic [9:0] m;
    m = w;
    if (GRADE_TIE >= 1)
      m[0] = 1'b0;
    if (GRADE_TIE >= 2)
      m[1] = 1'b0;
    return m;
  endfunction

  // Go toggle synchroniser; the word is stable while busy so it is sampled directly
  always_ff @(posedge i_link_clk or posedge i_reset)
  begin
    if (i_reset)
      go_sync_r <= 3'h0;
    else
      go_sync_r <= {go_sync_r[1:0], go_tgl_r};
  end

  // Transfer sequencer
  always_ff @(posedge i_link_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r                  <= DIL_ST_IDLE;
      word_r                   <= 10'h000;
      lmode_r                  <= DIL_MODE_SINGLE;
      bit_r                    <= 4'h0;
      cnt_r                    <= 16'h0000;
      phase_r                  <= 1'b0;
      link_done_tgl_r          <= 1'b0;
      o_parallel_data_bits     <= 10'h000;
      o_low_byte_strobe        <= 1'b0;
      o_high_byte_strobe       <= 1'b0;
      o_register_load_level    <= 1'b0;
      o_serial_parallel_select <= 1'b0;
      o_short_cycle_n          <= 1'b1;
      o_serial_data_in         <= 1'b0;
    end
    else
    begin
      case (state_r)
        DIL_ST_IDLE:
        begin
          if (go_sync_r[2] != go_sync_r[1])
          begin
            word_r  <= data_r;
            lmode_r <= dil_mode_e'(mode_r);
            phase_r <= 1'b0;
            cnt_r   <= 16'h0000;
            o_serial_parallel_select <= mode_r[1];
            o_short_cycle_n <= (mode_r != DIL_MODE_SER8);
            if (mode_r[1])
            begin
              o_parallel_data_bits <= 10'h000;
              bit_r            <= (mode_r == DIL_MODE_SER8) ? 4'd8 : 4'd10;
              o_serial_data_in <= data_r[9];
            end
            else if (mode_r == DIL_MODE_TWO)
              o_parallel_data_bits <= {2'b00, data_r[7:0]};
            else
              o_parallel_data_bits <= grade_mask(data_r);
            state_r <= DIL_ST_SETUP;
          end
        end
        DIL_ST_SETUP:
        begin
          if (lmode_r == DIL_MODE_TWO)
            o_low_byte_strobe <= ~phase_r;
          else
            o_low_byte_strobe <= 1'b1;
          o_high_byte_strobe <= (lmode_r != DIL_MODE_TWO) || phase_r;
          cnt_r              <= 16'h0000;
          state_r            <= DIL_ST_HIGH;
        end
        DIL_ST_HIGH:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(`DIL_STB_HALF - 1))
          begin
            o_low_byte_strobe  <= 1'b0;
            o_high_byte_strobe <= 1'b0;
            cnt_r              <= 16'h0000;
            state_r            <= DIL_ST_LOW;
          end
        end
        DIL_ST_LOW:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(`DIL_STB_HALF - 1))
          begin
            cnt_r   <= 16'h0000;
            state_r <= DIL_ST_NEXT;
          end
        end
        DIL_ST_NEXT:
        begin
          if (lmode_r[1] && bit_r > 4'd1)
          begin
            bit_r            <= bit_r - 4'd1;
            word_r           <= {word_r[8:0], 1'b0};
            o_serial_data_in <= word_r[8];
            state_r          <= DIL_ST_SETUP;
          end
          else if (lmode_r == DIL_MODE_TWO && !phase_r)
          begin
            // bus free gap, then high bits
            o_parallel_data_bits <= 10'h000;
            cnt_r                <= cnt_r + 16'h0001;
            if (cnt_r == 16'(GAP_CYC - 1))
            begin
              o_parallel_data_bits <= {word_r[9:8], 8'h00};
              phase_r              <= 1'b1;
              state_r              <= DIL_ST_SETUP;
            end
          end
          else
          begin
            o_register_load_level <= 1'b1;
            cnt_r                 <= 16'h0000;
            state_r               <= DIL_ST_DONE;
          end
        end
        DIL_ST_DONE:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(LINK_LOAD - 1))
          begin
            o_register_load_level <= 1'b0;
            o_serial_data_in      <= 1'b0;
            link_done_tgl_r       <= ~link_done_tgl_r;
            state_r               <= DIL_ST_IDLE;
          end
        end
        default:
          state_r <= DIL_ST_IDLE;
      endcase
    end
  end

  // Shadow of the loaded word for readback, captured in the link domain
  always_ff @(posedge i_link_clk or posedge i_reset)
  begin
    if (i_reset)
      shadow_r <= 10'h000;
    else if (state_r == DIL_ST_IDLE && go_sync_r[2] != go_sync_r[1])
      shadow_r <= data_r;
  end

  // Shadow is stable once done returns, so the system side copies it then
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      readbk_r <= 10'h000;
    else if (done_sync_r[2] != done_sync_r[1])
      readbk_r <= shadow_r;
  end

endmodule

// ### dil_chk_sva.sv
// Assertions on the DAC pin side of the loading controller
`timescale 1ns/100ps
module dil_chk
(
  input  wire logic       i_link_clk,
  input  wire logic       i_reset,
  input  wire logic [9:0] o_parallel_data_bits,
  input  wire logic       o_low_byte_strobe,
  input  wire logic       o_high_byte_strobe,
  input  wire logic       o_register_load_level,
  input  wire logic       o_serial_parallel_select,
  input  wire logic       o_short_cycle_n,
  input  wire logic       o_serial_data_in
);
  default clocking @(posedge i_link_clk); endclocking
  default disable iff (i_reset);
  logic       lbs_q_r;
  logic [3:0] edges_r;
  ////////////////////////////////////////////////////////////////
  // Strobe edges since the last load; cleared by the load so each frame counts alone
  always_ff @(posedge i_link_clk or posedge i_reset)
    if (i_reset)
    begin
      lbs_q_r <= 1'b0;
      edges_r <= 4'h0;
    end
    else
    begin
      lbs_q_r <= o_low_byte_strobe;
      if (o_register_load_level)
        edges_r <= 4'h0;
      else if (o_low_byte_strobe && !lbs_q_r)
        edges_r <= edges_r + 4'h1;
    end
  // Seven link clocks of 80 ns cover the minimum load time
  sequence s_load_held;
    o_register_load_level [*7];
  endsequence
  sequence s_load_gone;
    ##[7:40] !o_register_load_level;
  endsequence
  ////////////////////////////////////////////////////////////////
  // load level width
  chk_load_width: assert property ($rose(o_register_load_level) |-> s_load_held)
    else $error("load level too short");
  chk_load_ends: assert property ($rose(o_register_load_level) |-> s_load_gone)
    else $error("load level never falls");
  chk_load_after: assert property ($rose(o_register_load_level) |-> !o_low_byte_strobe && !o_high_byte_strobe)
    else $error("load level rose during a strobe");
  chk_data_setup: assert property ($rose(o_low_byte_strobe || o_high_byte_strobe) |-> $stable(o_parallel_data_bits))
    else $error("data changed at strobe edge");
  chk_serial_low: assert property (o_serial_parallel_select && (o_low_byte_strobe || o_high_byte_strobe)
    |-> o_parallel_data_bits == 10'h000)
    else $error("data pins not low in serial mode");
  chk_serial_joint: assert property (o_serial_parallel_select |-> o_low_byte_strobe == o_high_byte_strobe)
    else $error("serial strobes not joint");
  chk_edge_count: assert property ($rose(o_register_load_level) && o_serial_parallel_select
    |-> edges_r == (o_short_cycle_n ? 4'ha : 4'h8))
    else $error("wrong count of serial edges");
  chk_bit_setup: assert property (o_serial_parallel_select && $rose(o_low_byte_strobe) |-> $stable(o_serial_data_in))
    else $error("serial bit changed at edge");
  chk_mode_steady: assert property (o_low_byte_strobe || o_high_byte_strobe
    |-> $stable(o_serial_parallel_select) && $stable(o_short_cycle_n))
    else $error("mode pins moved during strobe");
endmodule
bind dil_ctrl dil_chk u_chk
(
  .i_link_clk(i_link_clk), .i_reset(i_reset), .o_parallel_data_bits(o_parallel_data_bits),
  .o_low_byte_strobe(o_low_byte_strobe), .o_high_byte_strobe(o_high_byte_strobe),
  .o_register_load_level(o_register_load_level), .o_serial_parallel_select(o_serial_parallel_select),
  .o_short_cycle_n(o_short_cycle_n), .o_serial_data_in(o_serial_data_in)
);

// ### dil_dac_model.sv
// Behavioural model of the buffered 10-bit DAC at the pins
`timescale 1ns/100ps
module dil_dac_model
(
  input  wire logic [9:0] i_parallel_data_bits,
  input  wire logic       i_low_byte_strobe,
  input  wire logic       i_high_byte_strobe,
  input  wire logic       i_register_load_level,
  input  wire logic       i_serial_parallel_select,
  input  wire logic       i_short_cycle_n,
  input  wire logic       i_serial_data_in,
  output logic            o_serial_data_out,
  output logic      [9:0] o_dac_reg
);
  logic [9:0] hold_r = 10'h000;
  initial o_dac_reg = 10'h000;
  // low strobe edge; serial shifts only here since both strobes rise together
  always @(posedge i_low_byte_strobe)
    if (!i_serial_parallel_select)
      hold_r[7:0] <= i_parallel_data_bits[7:0];
    else if (i_short_cycle_n)
      hold_r <= {hold_r[8:0], i_serial_data_in};
    else
      hold_r <= {hold_r[8:2], i_serial_data_in, i_parallel_data_bits[1:0]};
  always @(posedge i_high_byte_strobe)
    if (!i_serial_parallel_select)
      hold_r[9:8] <= i_parallel_data_bits[9:8];
  always @(i_register_load_level or hold_r)
    if (i_register_load_level)
      o_dac_reg = hold_r;
  assign o_serial_data_out = hold_r[9];
endmodule

// ### tb.sv
// Self-checking bench for the DAC input loading controller
`timescale 1ns/100ps
`include "dil_defs.svh"
module tb import dil_pkg::*;;
  logic        clk;
  logic        lclk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [9:0]  pins;
  logic [9:0]  dac;
  logic        low_byte_strobe, high_byte_strobe, load, sel, shn, sdi, sdo;
  int          errors;
  int          total_checks;
  dil_ctrl dut
  (
    .i_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_parallel_data_bits(pins), .o_low_byte_strobe(low_byte_strobe),
    .o_high_byte_strobe(high_byte_strobe), .o_register_load_level(load), .o_serial_parallel_select(sel),
    .o_short_cycle_n(shn), .o_serial_data_in(sdi), .i_serial_data_out(sdo)
  );
  dil_dac_model dac_m
  (
    .i_parallel_data_bits(pins), .i_low_byte_strobe(low_byte_strobe), .i_high_byte_strobe(high_byte_strobe),
    .i_register_load_level(load), .i_serial_parallel_select(sel), .i_short_cycle_n(shn),
    .i_serial_data_in(sdi), .o_serial_data_out(sdo), .o_dac_reg(dac)
  );
  ////////////////////////////////////////////////////////////////
  // Clocks; the link clock is offset so its edges keep a fixed 0.2 ns lead on system clock edges
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7.3;
    forever #40 lclk = ~lclk;
  end
  ////////////////////////////////////////////////////////////////
  // Bus cycles: one strobe cycle each, read data taken in the cycle after
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic cmp(input logic [15:0] exp, input logic [15:0] act, input string m);
    total_checks++;
    if (act !== exp)
    begin
      errors++;
      $display("mismatch t=%0t %s exp %h got %h", $time, m, exp, act);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One load; late writes a new word while busy, which must be ignored
  task automatic run_op(input logic [9:0] w, input dil_mode_e md, input logic [9:0] ex, input logic late);
    int n;
    wr_reg(`DIL_ADDR_DATA, {6'h00, w});
    wr_reg(`DIL_ADDR_CTRL, {13'h0000, 1'b1, md});
    if (late)
      wr_reg(`DIL_ADDR_DATA, 16'h0155);
    // The transfer takes microseconds, so busy must show and done must not yet
    rd_reg(`DIL_ADDR_STATUS);
    cmp(16'h0001, got & 16'h0003, "busy while loading");
    n = 0;
    got = 16'h0000;
    while (got[`DIL_STAT_DONE] !== 1'b1 && n < 2000)
    begin
      rd_reg(`DIL_ADDR_STATUS);
      n++;
    end
    if (got[`DIL_STAT_DONE] !== 1'b1)
    begin
      errors++;
      $display("mismatch t=%0t no done", $time);
      tally_and_finish();
    end
    cmp({6'h00, ex}, {6'h00, dac}, "dac word");
    rd_reg(`DIL_ADDR_DATA);
    cmp({6'h00, w}, got, "data reg");
    rd_reg(`DIL_ADDR_CTRL);
    cmp({14'h0000, md}, got, "ctrl reg");
    rd_reg(`DIL_ADDR_READBK);
    cmp({6'h00, w}, got, "readback");
    rd_reg(`DIL_ADDR_STATUS);
    cmp({13'h0000, ex[9], 2'b00}, got, "status");
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    cmp(16'h0001, {1'b0, pins, low_byte_strobe, high_byte_strobe, load, sel, shn}, "idle pins");
    rd_reg(`DIL_ADDR_DATA);
    cmp({6'h00, `DIL_DATA_RST}, got, "data reset");
    rd_reg(4'hf);
    cmp(16'h0000, got, "unmapped");
    cmp(16'h0000, {6'h00, dac}, "dac held");
    $display("test reset done");
  endtask
  task automatic t_parallel();
    run_op(10'h3a5, DIL_MODE_SINGLE, 10'h3a5, 1'b0);
    run_op(10'h200, DIL_MODE_SINGLE, 10'h200, 1'b0);
    run_op(10'h15a, DIL_MODE_TWO, 10'h15a, 1'b0);
    $display("test parallel done");
  endtask
  task automatic t_serial();
    run_op(10'h2c7, DIL_MODE_SER10, 10'h2c7, 1'b0);
    run_op(10'h2c7, DIL_MODE_SER8, 10'h2c4, 1'b0);
    $display("test serial done");
  endtask
  task automatic t_busy();
    run_op(10'h0f3, DIL_MODE_TWO, 10'h0f3, 1'b1);
    $display("test busy done");
  endtask
  initial
  begin
    errors = 0;
    total_checks = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_parallel();
    t_serial();
    t_busy();
    tally_and_finish();
  end
endmodule
